// *** design/sfr_defs.vh ***
// Constants for the special function register file: file addresses, field
// positions, reset values and instruction operands.
// Assumes it is included by bare name from each design file that uses it.
`ifndef SFR_DEFS_VH
`define SFR_DEFS_VH
`define SFR_ADDR_INDIRECT     5'h00
`define SFR_ADDR_COUNT        5'h01
`define SFR_ADDR_PCL          5'h02
`define SFR_ADDR_FLAGS        5'h03
`define SFR_ADDR_POINTER      5'h04
`define SFR_ADDR_PORT_REG     5'h05
`define SFR_ADDR_PORT_HV      5'h06
`define SFR_ADDR_GP07         5'h07
`define SFR_DIR_OP_PORT_REG   3'h5
`define SFR_DIR_OP_PORT_HV    3'h6
`define SFR_DIR_OP_WAKE_CFG   3'h7
`define SFR_FLAG_WAKE_CAUSE   7
`define SFR_FLAG_TIMEOUT      4
`define SFR_FLAG_POWER_DOWN   3
`define SFR_CFG_WAKE_DIS      5
`define SFR_CFG_WDOG_DIS      4
`define SFR_CFG_REG_LEVEL     3
`define SFR_CFG_SLEEP_LEVEL   2
`define SFR_CFG_BOR_LEVEL     1
`define SFR_CFG_BOR_DIS       0
`define SFR_POR_FLAGS         8'h98
`define SFR_POR_POINTER       8'h80
`define SFR_POR_PCL           8'hFF
`define SFR_POR_DIR           8'hFF
`define SFR_POR_TIMER_CFG     6'h3F
`define SFR_POR_WAKE_CFG      6'h3F
`define SFR_PORT_REG_MASK     8'h0F
`endif

// *** design/sfr_sync.v ***
// Two-flop synchroniser bank for pin inputs.
// Assumes the inputs are asynchronous to clk.
`timescale 1ns/100ps
`default_nettype none
module sfr_sync #(
    parameter WIDTH = 12
) (
    input  wire             clk,   // Instruction clock.
    input  wire [WIDTH-1:0] d,     // Asynchronous inputs.
    output reg  [WIDTH-1:0] q      // Synchronised outputs.
);
    reg [WIDTH-1:0] meta;
    always @(posedge clk) begin
        meta <= d;
        q    <= meta;
    end
endmodule // sfr_sync
`default_nettype wire

// *** design/sfr_wake_cfg.v ***
// Extended option register and the control levels it drives.
// Assumes the direction-load strobe is a one-cycle pulse on clk.
`timescale 1ns/100ps
`default_nettype none
`include "sfr_defs.vh"
module sfr_wake_cfg (
    input  wire       clk,              // Instruction clock.
    input  wire       por,              // Power-on reset, high.
    input  wire       load,             // Direction load with operand 07h.
    input  wire [7:0] wdata,            // Working register value.
    output reg        wake_on_change_disable, // High disables pin-change wake.
    output reg        soft_watchdog_disable,  // High disables watchdog.
    output reg        regulator_level_select, // High 5 V, low 3 V.
    output reg        sleep_level_select,     // High follows run level.
    output reg        brownout_level_select,  // Brown-out level choice.
    output reg        brownout_disable        // High disables brown-out.
);
    // Only power-on resets this register; master clear keeps the settings.
    always @(posedge clk) begin
        if (por) begin
            {wake_on_change_disable, soft_watchdog_disable, regulator_level_select,
             sleep_level_select, brownout_level_select, brownout_disable}
                <= `SFR_POR_WAKE_CFG;
        end else if (load) begin
            wake_on_change_disable <= wdata[`SFR_CFG_WAKE_DIS];
            soft_watchdog_disable  <= wdata[`SFR_CFG_WDOG_DIS];
            regulator_level_select <= wdata[`SFR_CFG_REG_LEVEL];
            sleep_level_select     <= wdata[`SFR_CFG_SLEEP_LEVEL];
            brownout_level_select  <= wdata[`SFR_CFG_BOR_LEVEL];
            brownout_disable       <= wdata[`SFR_CFG_BOR_DIS];
        end
    end
endmodule // sfr_wake_cfg
`default_nettype wire

// *** design/sfr_file.v ***
// Special function register file of a small 8-bit controller core.
// Assumes the core presents one file access per instruction cycle on clk,
// a synchronous data memory for indirect accesses, and pins that are
// asynchronous and are synchronised here.
// Indirect reads take memory data in the read cycle itself, so memory must
// present the byte at the current pointer without a wait state.
// The extended option register cannot be read back; software keeps a copy.
`timescale 1ns/100ps
`default_nettype none
`include "sfr_defs.vh"
// Behaviour
// - Address 00h reaches memory through pointer.
// - Only low counter byte at address 02h.
// - Wake flag set on power-on and sleep.
// - Wake flag cleared on pin-change wake.
// - Address 07h is plain storage.
// - Extended option loaded only by direction-load 07h.
// - Wake disable, regulator and sleep levels.
// - Watchdog disable, brown-out disable and level.
// - Extended option bits reset to one.
// - Unimplemented bits read as zero.
// - Master clear sets flags 100q quuu, pointer bit7.
module sfr_file (
    input  wire        clk,              // Instruction clock.
    input  wire        reset,            // Power-on reset, high, synchronous.
    input  wire        master_clear_input_reset,       // Master clear or watchdog reset.
    input  wire        wdog_timeout,     // Reset cause was watchdog, with master_clear_input_reset.
    input  wire        wdog_sleep_wake,  // Watchdog woke the part from sleep.
    input  wire [4:0]  file_addr,        // File address of the access.
    input  wire        file_rd,          // Read strobe.
    input  wire        file_wr,          // Write strobe.
    input  wire [7:0]  file_wdata,       // Write data.
    input  wire        dir_load,         // Direction-load instruction strobe.
    input  wire [2:0]  dir_operand,      // Direction-load operand.
    input  wire        timer_cfg_load,   // Timer option load strobe.
    input  wire        sleep_exec,       // Sleep instruction executed.
    input  wire        clrwdt_exec,      // Watchdog clear instruction executed.
    input  wire        count_tick,       // Free-running count increment.
    input  wire [7:0]  pc_next_low,      // Core's next counter low byte.
    input  wire        pc_advance,       // Core updates the counter low byte.
    input  wire [2:0]  alu_flags,        // Zero, nibble carry, carry from ALU.
    input  wire        alu_flags_wr,     // ALU flag update strobe.
    input  wire [7:0]  mem_rdata,        // Data memory read data.
    input  wire [11:0] pin_in,           // Pin levels, high port then low.
    output reg  [7:0]  file_rdata,       // Read data, one cycle after strobe.
    output reg  [7:0]  mem_addr,         // Data memory address.
    output reg  [7:0]  mem_wdata,        // Data memory write data.
    output reg         mem_wr,           // Data memory write strobe.
    output reg         mem_rd,           // Data memory read strobe.
    output reg  [7:0]  program_counter_low, // Low counter byte.
    output reg  [1:0]  page_select,      // Page select bits.
    output reg  [11:0] pin_out,          // Port output latches.
    output reg  [11:0] pin_oe,           // Port output enables, high drives.
    output reg  [5:0]  timer_prescaler_config, // Timer option register.
    output reg         wake_event,       // Pin-change wake pulse to the core.
    output reg         asleep,           // Core is in sleep.
    output reg         wake_on_change_disable, // High disables pin-change wake.
    output reg         soft_watchdog_disable,  // High disables watchdog.
    output reg         regulator_level,  // Active regulator level, high 5 V.
    output reg         brownout_level_select,  // Brown-out level choice.
    output reg         brownout_disable  // High disables brown-out.
);
    reg  [7:0]  free_running_count;
    reg  [7:0]  core_flags;
    reg  [7:0]  indirect_pointer;
    reg  [7:0]  general_07;
    reg  [7:0]  pin_direction_control_hv;
    reg  [3:0]  pin_direction_control_reg;
    reg  [11:0] latch;
    reg  [7:0]  hv_prev;
    wire [11:0] pin_sync;
    wire        cfg_load;
    wire        cfg_wake_dis;
    wire        cfg_wdog_dis;
    wire        cfg_reg_level;
    wire        cfg_sleep_level;
    wire        cfg_bor_level;
    wire        cfg_bor_dis;
    wire        any_reset;
    wire        pin_change;
    wire        wr_indirect;
    reg  [7:0]  next_rdata;
    wire        hv_changed;
    wire [11:0] dir_all;
    localparam [7:0] DIR_POR = `SFR_POR_DIR;

    // Master clear shares the direction, timer option and sleep resets.
    assign any_reset   = reset | master_clear_input_reset;
    // Other direction-load operands only reach the port direction registers.
    assign cfg_load    = dir_load & (dir_operand == `SFR_DIR_OP_WAKE_CFG);
    assign wr_indirect = file_wr & (file_addr == `SFR_ADDR_INDIRECT);
    // A change is judged against the levels seen as sleep began, so a pin
    // that already sat high when the core slept does not wake it again.
    assign hv_changed  = (pin_sync[11:4] != hv_prev);
    assign pin_change  = asleep & ~cfg_wake_dis & hv_changed;
    assign dir_all     = {pin_direction_control_hv, pin_direction_control_reg};

    // Pins are only read through the second stage; the first may be metastable.
    sfr_sync #(
        .WIDTH (12)
    ) u_sync (
        .clk (clk),
        .d   (pin_in),
        .q   (pin_sync)
    );

    // The option register lives apart because only power-on resets it; a
    // master clear must leave the regulator and brown-out settings alone.
    sfr_wake_cfg u_cfg (
        .clk                    (clk),
        .por                    (reset),
        .load                   (cfg_load),
        .wdata                  (file_wdata),
        .wake_on_change_disable (cfg_wake_dis),
        .soft_watchdog_disable  (cfg_wdog_dis),
        .regulator_level_select (cfg_reg_level),
        .sleep_level_select     (cfg_sleep_level),
        .brownout_level_select  (cfg_bor_level),
        .brownout_disable       (cfg_bor_dis)
    );

    // Register the config levels so outputs come from flops; the settings
    // reach the analogue outputs one cycle after the load lands, while the wake logic uses cfg_wake_dis at once.
    always @(posedge clk) begin
        wake_on_change_disable <= cfg_wake_dis;
        soft_watchdog_disable  <= cfg_wdog_dis;
        brownout_level_select  <= cfg_bor_level;
        brownout_disable       <= cfg_bor_dis;
        // Sleep forces 3 V unless the sleep level follows the run level.
        regulator_level <= cfg_reg_level & (~asleep | cfg_sleep_level);
    end

    // Indirect accesses go out to data memory; no storage sits at 00h.
    // Strobe, address and data leave together from flops, so memory sees one
    // clean set per access and nothing glitches between instruction cycles.
    always @(posedge clk) begin
        if (reset) begin
            mem_wr    <= 1'b0;
            mem_rd    <= 1'b0;
            mem_addr  <= 8'h00;
            mem_wdata <= 8'h00;
        end else begin
            mem_wr    <= wr_indirect;
            mem_rd    <= file_rd & (file_addr == `SFR_ADDR_INDIRECT);
            mem_addr  <= indirect_pointer;
            mem_wdata <= file_wdata;
        end
    end

    // Unmapped addresses and the missing upper bits of the regulated port
    // read as zero, so software polling a spare address sees a fixed value.
    always @* begin
        next_rdata = 8'h00;
        case (file_addr)
            `SFR_ADDR_INDIRECT: next_rdata = mem_rdata;
            `SFR_ADDR_COUNT:    next_rdata = free_running_count;
            `SFR_ADDR_PCL:      next_rdata = program_counter_low;
            `SFR_ADDR_FLAGS:    next_rdata = core_flags;
            `SFR_ADDR_POINTER:  next_rdata = indirect_pointer;
            `SFR_ADDR_PORT_REG: next_rdata = {4'h0, pin_sync[3:0]};
            `SFR_ADDR_PORT_HV:  next_rdata = pin_sync[11:4];
            `SFR_ADDR_GP07:     next_rdata = general_07;
            default:            next_rdata = 8'h00;
        endcase
    end

    // Indirect read data is taken from mem_rdata in the read cycle itself, a cycle
    // before mem_rd reaches memory, so the mux is sampled with the strobe for address 00h.
    // Between reads the data holds, so the core may take it late.
    always @(posedge clk) begin
        if (reset) begin
            file_rdata <= 8'h00;
        end else if (file_rd) begin
            file_rdata <= next_rdata;
        end
    end

    // Master clear keeps the count, the port latches and address 07h; only
    // the counter byte and the top pointer bit are forced, so a program can
    // tell a warm restart from a cold one by what survived.
    always @(posedge clk) begin
        if (reset) begin
            program_counter_low <= `SFR_POR_PCL;
            free_running_count  <= 8'h00;
            indirect_pointer    <= `SFR_POR_POINTER;
            general_07          <= 8'h00;
            latch               <= 12'h000;
        end else if (master_clear_input_reset) begin
            program_counter_low <= `SFR_POR_PCL;
            indirect_pointer    <= indirect_pointer | `SFR_POR_POINTER;
        end else begin
            // Upper counter bits live in the core and are not reachable here.
            if (file_wr && file_addr == `SFR_ADDR_PCL)
                program_counter_low <= file_wdata;
            else if (pc_advance)
                program_counter_low <= pc_next_low;
            // A software write to the count beats the tick in the same cycle,
            // so a reload is never lost to an increment.
            if (file_wr && file_addr == `SFR_ADDR_COUNT)
                free_running_count <= file_wdata;
            else if (count_tick)
                free_running_count <= free_running_count + 8'h01;
            if (file_wr && file_addr == `SFR_ADDR_POINTER)
                indirect_pointer <= file_wdata;
            if (file_wr && file_addr == `SFR_ADDR_GP07)
                general_07 <= file_wdata;
            // Port writes land in the latches; reads return the pin levels.
            if (file_wr && file_addr == `SFR_ADDR_PORT_REG)
                latch[3:0] <= file_wdata[3:0];
            if (file_wr && file_addr == `SFR_ADDR_PORT_HV)
                latch[11:4] <= file_wdata;
        end
    end

    // Directions and timer option reset on every reset to all ones.
    // All pins come up as inputs, so nothing is driven until software has
    // set the latches and asked for it.
    always @(posedge clk) begin
        if (any_reset) begin
            pin_direction_control_hv  <= DIR_POR;
            pin_direction_control_reg <= DIR_POR[3:0];
            timer_prescaler_config    <= `SFR_POR_TIMER_CFG;
        end else begin
            if (dir_load && dir_operand == `SFR_DIR_OP_PORT_HV)
                pin_direction_control_hv <= file_wdata;
            if (dir_load && dir_operand == `SFR_DIR_OP_PORT_REG)
                pin_direction_control_reg <= file_wdata[3:0];
            // The timer option keeps only its six low bits.
            if (timer_cfg_load)
                timer_prescaler_config <= file_wdata[5:0];
        end
    end

    // A clear direction bit turns on the pin's driver; outputs lag the
    // latches by one cycle so every pin changes on the same edge.
    always @(posedge clk) begin
        pin_out <= latch;
        pin_oe  <= ~dir_all;
    end

    // Flags: wake cause, page bits, timeout, power down, then ALU bits.
    // Timeout and power down belong to hardware; software writes skip them.
    // Where the sleep or wake logic and a software write touch one bit in the same cycle,
    // that logic wins, so a wake or a sleep is never hidden by a flag write; a flag write beats an ALU update.
    always @(posedge clk) begin
        if (reset) begin
            core_flags <= `SFR_POR_FLAGS;
        end else if (master_clear_input_reset) begin
            // Wake cause set, page bits cleared; the ALU bits are kept.
            core_flags[7:5] <= 3'h4;
            core_flags[`SFR_FLAG_TIMEOUT]    <= ~wdog_timeout;
            core_flags[`SFR_FLAG_POWER_DOWN] <= ~asleep;
        end else begin
            if (file_wr && file_addr == `SFR_ADDR_FLAGS) begin
                core_flags[7:5] <= file_wdata[7:5];
                core_flags[2:0] <= file_wdata[2:0];
            end else if (alu_flags_wr) begin
                core_flags[2:0] <= alu_flags;
            end
            if (clrwdt_exec) begin
                core_flags[`SFR_FLAG_TIMEOUT]    <= 1'b1;
                core_flags[`SFR_FLAG_POWER_DOWN] <= 1'b1;
            end
            if (sleep_exec) begin
                core_flags[`SFR_FLAG_WAKE_CAUSE] <= 1'b1;
                core_flags[`SFR_FLAG_TIMEOUT]    <= 1'b1;
                core_flags[`SFR_FLAG_POWER_DOWN] <= 1'b0;
            end else if (pin_change) begin
                core_flags[`SFR_FLAG_WAKE_CAUSE] <= 1'b0;
            end
            if (wdog_sleep_wake)
                core_flags[`SFR_FLAG_TIMEOUT] <= 1'b0;
        end
    end

    // The page bits leave through a flop so the core never sees them mid-update.
    always @(posedge clk) begin
        page_select <= core_flags[6:5];
    end

    // Sleep state and pin-change detection on the high-voltage port.
    // The snapshot of the high port is taken as sleep begins; only the high
    // port can wake the part, the regulated port is ignored while asleep.
    // A watchdog wake ends sleep as well but leaves the wake cause set.
    always @(posedge clk) begin
        if (any_reset) begin
            asleep     <= 1'b0;
            wake_event <= 1'b0;
            hv_prev    <= 8'h00;
        end else begin
            wake_event <= pin_change;
            if (sleep_exec)
                hv_prev <= pin_sync[11:4];
            // Entering sleep wins over a wake in the same cycle.
            if (sleep_exec)
                asleep <= 1'b1;
            else if (pin_change || wdog_sleep_wake)
                asleep <= 1'b0;
        end
    end
endmodule // sfr_file
`default_nettype wire

// *** sim/sfr_file_checker.sv ***
// Port checker for sfr_file.
// Assumes one clock and a synchronous active-high power-on reset.
`timescale 1ns/100ps
`default_nettype none
module sfr_file_checker (
    input wire logic       clk,                    // Clock.
    input wire logic       reset,                  // Power-on reset.
    input wire logic       master_clear_input_reset,             // Master clear.
    input wire logic [4:0] file_addr,              // Address.
    input wire logic       file_rd,                // Read.
    input wire logic       file_wr,                // Write.
    input wire logic [7:0] file_wdata,             // Write data.
    input wire logic       dir_load,               // Direction load.
    input wire logic [2:0] dir_operand,            // Operand.
    input wire logic       sleep_exec,             // Sleep.
    input wire logic [7:0] file_rdata,             // Read data.
    input wire logic [7:0] mem_wdata,              // Memory data.
    input wire logic       mem_wr,                 // Memory write.
    input wire logic       mem_rd,                 // Memory read.
    input wire logic [7:0] program_counter_low,    // Counter byte.
    input wire logic       asleep,                 // Sleeping.
    input wire logic       wake_on_change_disable, // Option bit.
    input wire logic       soft_watchdog_disable,  // Option bit.
    input wire logic       regulator_level,        // Level.
    input wire logic       brownout_level_select,  // Option bit.
    input wire logic       brownout_disable        // Option bit.
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    wire       cfg_ld = dir_load && dir_operand == 3'h7;
    wire [3:0] cfg    = {wake_on_change_disable, soft_watchdog_disable,
                         brownout_level_select, brownout_disable};
    a_indirect_read: assert property (file_rd && file_addr == 5'h00 |=> mem_rd)
        else $error("indirect read gave no memory read");
    a_indirect_write: assert property (file_wr && file_addr == 5'h00 |=>
        mem_wr && mem_wdata == $past(file_wdata)) else $error("indirect write lost");
    a_option_applied: assert property (cfg_ld ##1 1'b1 |=>
        cfg == {$past(file_wdata[5:4], 2), $past(file_wdata[1:0], 2)})
        else $error("option load wrong");
    a_option_hold: assert property (!cfg_ld ##1 !cfg_ld |=> $stable(cfg))
        else $error("option changed without load");
    a_run_level: assert property (cfg_ld && !asleep && !sleep_exec ##1 !sleep_exec |=>
        regulator_level == $past(file_wdata[3], 2)) else $error("run level wrong");
    a_sleep_entry: assert property (sleep_exec && !master_clear_input_reset |=> asleep)
        else $error("sleep not entered");
    a_clear_counter: assert property (master_clear_input_reset |=> program_counter_low == 8'hFF)
        else $error("counter not reset by master clear");
    a_port_high_zero: assert property (file_rd && file_addr == 5'h05 |=>
        file_rdata[7:4] == 4'h0) else $error("port upper bits not zero");
    c_indirect: cover property (file_rd && file_addr == 5'h00);
    c_option: cover property (cfg_ld);
    c_sleep_wake: cover property (sleep_exec ##[1:30] !asleep);
endmodule // sfr_file_checker
bind sfr_file sfr_file_checker u_checker (.clk, .reset, .master_clear_input_reset, .file_addr, .file_rd,
    .file_wr, .file_wdata, .dir_load, .dir_operand, .sleep_exec, .file_rdata, .mem_wdata,
    .mem_wr, .mem_rd, .program_counter_low, .asleep, .wake_on_change_disable,
    .soft_watchdog_disable, .regulator_level, .brownout_level_select, .brownout_disable);
`default_nettype wire

// *** sim/tb_special_function_register_file.sv ***
// Directed bench for sfr_file: each task drives one scenario and checks it.
// Assumes design/ is on the include path and the port checker is bound.
`timescale 1ns/100ps
`default_nettype none
module tb_special_function_register_file;
    logic        clk, reset, master_clear_input_reset, wdog_timeout, wdog_sleep_wake, file_rd, file_wr;
    logic        dir_load, timer_cfg_load, sleep_exec, pc_advance, alu_flags_wr;
    logic [4:0]  file_addr;
    logic [7:0]  file_wdata, pc_next_low, mem_rdata, rdata, mwdata;
    logic [2:0]  dir_operand, alu_flags;
    logic [9:0]  mseen;
    logic [11:0] pin_in;
    wire  [7:0]  file_rdata, mem_addr, mem_wdata, program_counter_low;
    wire         mem_wr, mem_rd, wake_event, asleep, regulator_level, brownout_disable;
    wire         wake_on_change_disable, soft_watchdog_disable, brownout_level_select;
    wire  [1:0]  page_select;
    wire  [11:0] pin_out, pin_oe;
    wire  [5:0]  timer_prescaler_config;
    wire  [4:0]  cfg = {wake_on_change_disable, soft_watchdog_disable,
                        brownout_level_select, brownout_disable, regulator_level};
    int          num_errors = 0;
    int          n_checks = 0;
    int          cycles = 0;

    sfr_file dut (.clk, .reset, .master_clear_input_reset, .wdog_timeout, .wdog_sleep_wake, .file_addr,
        .file_rd, .file_wr, .file_wdata, .dir_load, .dir_operand, .timer_cfg_load, .sleep_exec,
        .clrwdt_exec(1'b0), .count_tick(1'b0), .pc_next_low, .pc_advance, .alu_flags,
        .alu_flags_wr, .mem_rdata, .pin_in, .file_rdata, .mem_addr, .mem_wdata, .mem_wr,
        .mem_rd, .program_counter_low, .page_select, .pin_out, .pin_oe, .timer_prescaler_config,
        .wake_event, .asleep, .wake_on_change_disable, .soft_watchdog_disable, .regulator_level,
        .brownout_level_select, .brownout_disable);

    task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] got);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic step;
        @(posedge clk);
        #1;
    endtask
    // Strobes drop for a full cycle so no input is assigned twice in one time step.
    task automatic acc(input logic rd, input logic [4:0] a, input logic [7:0] d);
        {file_addr, file_rd, file_wr, file_wdata} = {a, rd, !rd, d};
        step();
        {rdata, mseen, mwdata} = {file_rdata, mem_wr, mem_rd, mem_addr, mem_wdata};
        {file_rd, file_wr} = 2'b00;
        step();
    endtask
    task automatic pulse(ref logic s);
        s = 1'b1;
        step();
        s = 1'b0;
        step();
    endtask
    task automatic dir(input logic [2:0] op, input logic [7:0] d);
        {dir_operand, file_wdata} = {op, d};
        pulse(dir_load);
    endtask
    task automatic t_reset;
        acc(1, 5'h03, 8'h00);
        chk("flags", 8'h98, rdata);
        acc(1, 5'h02, 8'h00);
        chk("pcl", 8'hFF, rdata);
        chk("option", 5'h1F, cfg);
        $display("test reset done");
    endtask
    task automatic t_store;
        for (int i = 0; i < 2; i++) begin
            acc(0, 5'h07, i ? 8'h5A : 8'hA5);
            acc(1, 5'h07, 8'h00);
            chk("gp07", i ? 8'h5A : 8'hA5, rdata);
        end
        dir(3'h5, 8'h0F);
        chk("option kept", 5'h1F, cfg);
        dir(3'h6, 8'h0F);
        acc(0, 5'h06, 8'h5A);
        chk("pins", {8'h5A, 12'hF00}, {pin_out[11:4], pin_oe});
        acc(0, 5'h08, 8'hFF);
        acc(1, 5'h08, 8'h00);
        chk("unmapped", 8'h00, rdata);
        pin_in = {8'hC3, 4'hA};
        repeat (3) step();
        acc(1, 5'h05, 8'h00);
        chk("low port", 8'h0A, rdata);
        $display("test storage done");
    endtask
    task automatic t_indirect;
        acc(0, 5'h04, 8'hFC);
        mem_rdata = 8'h3C;
        acc(1, 5'h00, 8'h00);
        chk("ind read", 8'h3C, rdata);
        chk("mem read", {2'b01, 8'hFC}, mseen);
        acc(0, 5'h00, 8'h66);
        chk("mem write", {2'b10, 8'hFC, 8'h66}, {mseen, mwdata});
        // Memory now differs from the byte written, so a real register at 00h would show.
        mem_rdata = 8'h99;
        acc(1, 5'h00, 8'h00);
        chk("ind reread", 8'h99, rdata);
        $display("test indirect done");
    endtask
    task automatic t_option;
        logic [7:0] pat [3] = '{8'hC0, 8'h15, 8'h2A};
        for (int i = 0; i < 3; i++) begin
            dir(3'h7, pat[i]);
            chk("option", {pat[i][5:4], pat[i][1:0], pat[i][3]}, cfg);
        end
        $display("test option done");
    endtask
    task automatic t_sleep(input logic [7:0] opt, input logic wake);
        logic seen;
        dir(3'h7, opt);
        pulse(sleep_exec);
        chk("asleep", 1'b1, asleep);
        chk("sleep level", opt[3] & opt[2], regulator_level);
        acc(1, 5'h03, 8'h00);
        chk("sleep flags", 8'h80, rdata & 8'h88);
        pin_in[4] = !pin_in[4];
        seen = 1'b0;
        repeat (8) begin
            step();
            seen = seen | wake_event;
        end
        chk("pin wake", wake, seen);
        if (!wake)
            pulse(wdog_sleep_wake);
        acc(1, 5'h03, 8'h00);
        chk("wake flag", {!wake, 1'b0}, {rdata[7], asleep});
        $display("test sleep done");
    endtask
    task automatic t_clear;
        acc(0, 5'h03, 8'h60);
        alu_flags = 3'b101;
        pulse(alu_flags_wr);
        acc(0, 5'h04, 8'h1C);
        acc(0, 5'h07, 8'h3E);
        file_wdata = 8'h05;
        pulse(timer_cfg_load);
        chk("timer cfg", 6'h05, timer_prescaler_config);
        pc_next_low = 8'h34;
        pulse(pc_advance);
        acc(1, 5'h02, 8'h00);
        chk("pcl", 8'h34, rdata);
        for (int i = 0; i < 2; i++) begin
            wdog_timeout = i[0];
            pulse(master_clear_input_reset);
            acc(1, 5'h03, 8'h00);
            chk("flags", i ? 8'h8D : 8'h9D, rdata);
            acc(1, 5'h04, 8'h00);
            chk("pointer", 8'h9C, rdata);
            acc(1, 5'h07, 8'h00);
            chk("gp07 kept", 8'h3E, rdata);
        end
        chk("after clear", {8'hFF, 2'b00, 4'h8, 6'h3F},
            {program_counter_low, page_select, cfg[4:1], timer_prescaler_config});
        chk("pins kept", {8'h5A, 12'h000}, {pin_out[11:4], pin_oe});
        $display("test master clear done");
    endtask
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            num_errors++;
            $display("BAD timeout expected 0 seen %0d", cycles);
            end_of_test();
        end
    end
    initial begin
        reset = 1'b1;
        {master_clear_input_reset, wdog_timeout, wdog_sleep_wake, file_rd, file_wr, dir_load} = 6'h00;
        {timer_cfg_load, sleep_exec, pc_advance, alu_flags_wr, alu_flags, dir_operand} = 10'h000;
        {file_addr, file_wdata, pc_next_low, mem_rdata, pin_in} = 41'h0;
        repeat (8) @(posedge clk);
        #1;
        reset = 1'b0;
        t_reset();
        t_store();
        t_indirect();
        t_option();
        t_sleep(8'h0C, 1'b1);
        t_sleep(8'h28, 1'b0);
        t_clear();
        end_of_test();
    end
endmodule // tb_special_function_register_file
`default_nettype wire
